//--- mce_divider.sv
`default_nettype none

module mce_divider (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [31:0] dividend,
   input  wire logic [31:0] divisor,
   output logic             busy,
   output logic             done,
   output logic      [31:0] quotient
);
   import mce_pkg::*;

   typedef struct packed {
      logic [31:0] rem;
      logic [31:0] quo;
      logic [31:0] den;
      logic [5:0]  cnt;
      logic        busy;
      logic        done;
   } mce_div_state_t;

   mce_div_state_t st;
   mce_div_state_t nxt_st;
   logic [32:0]    remSh;
   logic [32:0]    diff;

   // ======================================================================
   // Restoring division, one quotient bit per cycle; a zero divisor
   // gives all ones, so the caller must guard it
   always_comb begin
      nxt_st      = st;
      nxt_st.done = 1'b0;
      remSh       = {st.rem, st.quo[31]};
      diff        = remSh - {1'b0, st.den};
      if (st.busy) begin
         if (!diff[32]) begin
            nxt_st.rem = diff[31:0];
         end else begin
            nxt_st.rem = remSh[31:0];
         end
         nxt_st.quo = {st.quo[30:0], ~diff[32]};
         nxt_st.cnt = st.cnt - 6'h01;
         if (st.cnt == 6'h01) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
         end
      end else if (start) begin
         nxt_st.rem  = '0;
         nxt_st.quo  = dividend;
         nxt_st.den  = divisor;
         nxt_st.cnt  = 6'h20;
         nxt_st.busy = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nxt_st;
      end
   end

   assign busy     = st.busy;
   assign done     = st.done;
   assign quotient = st.quo;
endmodule

`default_nettype wire

//--- mce_field_model.sv
`default_nettype none

// ==========================================
// Field side: encoders and pin drivers
module mce_field_model (
   input  wire logic        sys_clk,
   input  wire logic [31:0] gpioPinOut,
   input  wire logic [31:0] gpioOeN,
   input  wire logic [31:0] fieldDrive,
   output logic      [31:0] gpioPinIn,
   output var logic  [5:0]  encA,
   output var logic  [5:0]  encB,
   output var logic  [5:0]  encIdx
);
   timeunit 1ns;
   timeprecision 1ps;
   int phase [6] = '{default: 0};

   // Card drives where its enable is low, field drivers hold every other pin
   assign gpioPinIn = (gpioPinOut & ~gpioOeN) | (fieldDrive & gpioOeN);

   initial begin
      encA = '0;
      encB = '0;
      encIdx = '0;
   end

   // Quadrature, A leads B going up; levels held well past the input filter
   task automatic quad(input int ax, input int n, input int gap);
      for (int i = 0; i < (n < 0 ? -n : n); i++) begin
         phase[ax] = (phase[ax] + (n < 0 ? 3 : 1)) % 4;
         @(posedge sys_clk);
         encA[ax] <= phase[ax] inside {1, 2};
         encB[ax] <= phase[ax] >= 2;
         repeat (gap) @(posedge sys_clk);
      end
   endtask

   // Step pulses on A with direction on B, direction set up first
   task automatic step(input int ax, input int n, input logic dir);
      @(posedge sys_clk);
      encB[ax] <= dir;
      repeat (n) begin
         repeat (6) @(posedge sys_clk);
         encA[ax] <= 1'b1;
         repeat (6) @(posedge sys_clk);
         encA[ax] <= 1'b0;
      end
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic setIdx(input int ax, input logic lvl);
      @(posedge sys_clk);
      encIdx[ax] <= lvl;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

`default_nettype wire

//--- mce_motion_io.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`default_nettype none

module mce_motion_io (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic [mce_pkg::ADDR_W-1:0]  addr,
   input  wire logic [mce_pkg::DATA_W-1:0]  wrData,
   input  wire logic                        wrStb,
   input  wire logic                        rdStb,
   output logic      [mce_pkg::DATA_W-1:0]  rdData,
   input  wire logic [mce_pkg::GPIO_W-1:0]  gpioPinIn,
   output logic      [mce_pkg::GPIO_W-1:0]  gpioPinOut,
   output logic      [mce_pkg::GPIO_W-1:0]  gpioOeN,
   input  wire logic [mce_pkg::AXES-1:0]    encA,
   input  wire logic [mce_pkg::AXES-1:0]    encB,
   input  wire logic [mce_pkg::AXES-1:0]    encIdx
);
   import mce_pkg::*;

   typedef struct packed {
      logic [GPIO_W-1:0]             gpioDir;
      logic [GPIO_W-1:0]             gpioInv;
      logic [GPIO_W-1:0]             gpioVal;
      logic [GPIO_W-1:0]             pinOut;
      logic [GPIO_W-1:0]             oeN;
      logic [DATA_W-1:0]             rdData;
      logic [7:0]                    tickCnt;
      logic [AXES-1:0]               prevA;
      logic [AXES-1:0]               prevB;
      logic [AXES-1:0]               prevI;
      logic [AXES-1:0]               stepDir;
      logic [AXES-1:0]               roundMode;
      logic [AXES-1:0]               idxInv;
      logic [AXES-1:0]               armed;
      logic [AXES-1:0]               cntReset;
      logic [AXES-1:0]               lastUp;
      logic [AXES-1:0]               posNeg;
      logic [AXES-1:0]               velNeg;
      logic [AXES-1:0]               velZero;
      logic [AXES-1:0][31:0]         cpr;
      logic [AXES-1:0][15:0]         scale;
      logic [AXES-1:0][31:0]         minSpd;
      logic [AXES-1:0][31:0]         count;
      logic [AXES-1:0][31:0]         raw;
      logic [AXES-1:0][31:0]         phase;
      logic [AXES-1:0][31:0]         posOut;
      logic [AXES-1:0][31:0]         velOut;
      logic [AXES-1:0][INT_W-1:0]    interval;
      logic [AXES-1:0][INT_W-1:0]    timer;
   } mce_top_state_t;

   mce_top_state_t           st;
   mce_top_state_t           nxt_st;
   logic [GPIO_W-1:0]        gpioSync;
   logic [3*AXES-1:0]        encSync;
   logic [AXES-1:0]          aS;
   logic [AXES-1:0]          bS;
   logic [AXES-1:0]          iS;
   logic [AXES-1:0]          posStart;
   logic [AXES-1:0]          posBusy;
   logic [AXES-1:0]          posDone;
   logic [AXES-1:0]          velStart;
   logic [AXES-1:0]          velBusy;
   logic [AXES-1:0]          velDone;
   logic [AXES-1:0][31:0]    posNum;
   logic [AXES-1:0][31:0]    posDen;
   logic [AXES-1:0][31:0]    posQuo;
   logic [AXES-1:0][31:0]    velDen;
   logic [AXES-1:0][31:0]    velQuo;
   logic [AXES-1:0][INT_W-1:0] effInt;
   logic [1:0]               page;
   logic [2:0]               axSel;
   logic [4:0]               axOff;
   logic                     axHit;

   // ======================================================================
   // Input synchronisers for field pins and encoder channels
   mce_sync #(.WIDTH(GPIO_W)) uGpioSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .din     (gpioPinIn),
      .dout    (gpioSync)
   );

   mce_sync #(.WIDTH(3*AXES)) uEncSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .din     ({encIdx, encB, encA}),
      .dout    (encSync)
   );

   assign aS = encSync[AXES-1:0];
   assign bS = encSync[2*AXES-1:AXES];
   assign iS = encSync[3*AXES-1:2*AXES];

   // ======================================================================
   // Address decode
   assign page  = addr[9:8];
   assign axSel = addr[7:5];
   assign axOff = addr[4:0];
   assign axHit = (page == PAGE_AXIS) && (axSel < 3'(AXES));

   // ======================================================================
   // Per-axis dividers run back to back, so position and velocity refresh
   // every 34 cycles without the host having to request them
   genvar g;
   generate
      for (g = 0; g < AXES; g++) begin : gAxis // [R5]
         assign posStart[g] = ~posBusy[g] & ~posDone[g];
         assign velStart[g] = ~velBusy[g] & ~velDone[g];
         assign posNum[g]   = st.count[g][31] ? (32'h0 - st.count[g]) : st.count[g];
         assign posDen[g]   = {16'h0000, st.scale[g]};
         assign effInt[g]   = (st.timer[g] > st.interval[g]) ? st.timer[g] : st.interval[g];
         assign velDen[g]   = {16'h0000, effInt[g]} * {16'h0000, st.scale[g]};

         mce_divider uPosDiv (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .start    (posStart[g]),
            .dividend (posNum[g]),
            .divisor  (posDen[g]),
            .busy     (posBusy[g]),
            .done     (posDone[g]),
            .quotient (posQuo[g])
         );

         mce_divider uVelDiv (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .start    (velStart[g]),
            .dividend (TIMER_HZ),
            .divisor  (velDen[g]),
            .busy     (velBusy[g]),
            .done     (velDone[g]),
            .quotient (velQuo[g])
         );
      end
   endgenerate

   // ======================================================================
   // Next-state logic: GPIO, counters, timers, results, register bus
   always_comb begin
      logic        v;
      logic        up;
      logic        idxEv;
      logic        tick;
      logic [31:0] mag;
      v      = 1'b0;
      up     = 1'b0;
      idxEv  = 1'b0;
      mag    = '0;
      nxt_st = st;
      tick   = (st.tickCnt == TICK_LAST);
      nxt_st.tickCnt = tick ? 8'h00 : (st.tickCnt + 8'h01);
      nxt_st.rdData  = '0;

      // Pins drive only where direction is output; oe is active low
      nxt_st.pinOut = (st.gpioVal ^ st.gpioInv) & st.gpioDir;  // [R1] [R3] [R4]
      nxt_st.oeN    = ~st.gpioDir;                              // [R2]

      for (int a = 0; a < AXES; a++) begin
         // Edge decode on synchronised channels
         if (st.stepDir[a]) begin
            v  = aS[a] & ~st.prevA[a];                          // [R6] [R16]
            up = bS[a];
         end else begin
            case ({st.prevA[a], st.prevB[a], aS[a], bS[a]})    // [R17]
               4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
                  v  = 1'b1;
                  up = 1'b1;
               end
               4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
                  v  = 1'b1;
                  up = 1'b0;
               end
               default: begin
                  v  = 1'b0;
                  up = 1'b0;
               end
            endcase
         end
         idxEv = st.idxInv[a] ? (st.prevI[a] & ~iS[a]) : (~st.prevI[a] & iS[a]); // [R19]
         nxt_st.prevA[a] = aS[a];
         nxt_st.prevB[a] = bS[a];
         nxt_st.prevI[a] = iS[a];

         // Raw count sees every edge and nothing else
         if (v) begin
            nxt_st.raw[a] = up ? (st.raw[a] + 32'h1) : (st.raw[a] - 32'h1); // [R10]
         end

         // Reset beats index, index beats a coincident edge
         if (st.cntReset[a]) begin
            nxt_st.count[a] = '0;                               // [R9]
            nxt_st.phase[a] = '0;
         end else if (st.armed[a] && idxEv) begin
            if (st.roundMode[a] && (st.cpr[a] != 32'h0)) begin
               if ({st.phase[a], 1'b0} < {1'b0, st.cpr[a]}) begin
                  nxt_st.count[a] = st.count[a] - st.phase[a];  // [R18]
               end else begin
                  nxt_st.count[a] = st.count[a] + (st.cpr[a] - st.phase[a]);
               end
            end else begin
               nxt_st.count[a] = '0;                            // [R12]
            end
            nxt_st.phase[a] = '0;
            nxt_st.armed[a] = 1'b0;                             // [R13]
         end else if (v) begin
            nxt_st.count[a] = up ? (st.count[a] + 32'h1) : (st.count[a] - 32'h1); // [R7] [R8]
            // Phase within a revolution, so rounding needs no divide
            if (st.cpr[a] == 32'h0) begin
               nxt_st.phase[a] = '0;
            end else if (up) begin
               nxt_st.phase[a] = (st.phase[a] >= st.cpr[a] - 32'h1) ? 32'h0 : (st.phase[a] + 32'h1);
            end else begin
               nxt_st.phase[a] = (st.phase[a] == 32'h0 || st.phase[a] >= st.cpr[a]) ?
                                 (st.cpr[a] - 32'h1) : (st.phase[a] - 32'h1);
            end
         end

         // Edge interval in timer ticks; a stalled axis lets the timer win
         if (v) begin
            nxt_st.interval[a] = (st.timer[a] == '0) ? 16'h0001 : st.timer[a]; // [R14]
            nxt_st.timer[a]    = '0;
            nxt_st.lastUp[a]   = up;
         end else if (tick && st.timer[a] != INT_SAT) begin
            nxt_st.timer[a] = st.timer[a] + 16'h0001;
         end

         // Scaled position
         if (posStart[a]) begin
            nxt_st.posNeg[a] = st.count[a][31];
         end
         if (st.cntReset[a] || st.scale[a] == 16'h0) begin
            nxt_st.posOut[a] = '0;                              // [R9]
         end else if (posDone[a]) begin
            nxt_st.posOut[a] = st.posNeg[a] ? (32'h0 - posQuo[a]) : posQuo[a]; // [R11]
         end

         // Velocity; a saturated interval means the axis is standing
         if (velStart[a]) begin
            nxt_st.velNeg[a]  = ~st.lastUp[a];
            nxt_st.velZero[a] = (effInt[a] == INT_SAT) || (st.scale[a] == 16'h0);
         end
         if (velDone[a]) begin
            mag = velQuo[a];
            if (st.velZero[a] || mag < st.minSpd[a]) begin
               nxt_st.velOut[a] = '0;                           // [R15]
            end else begin
               nxt_st.velOut[a] = st.velNeg[a] ? (32'h0 - mag) : mag; // [R14]
            end
         end

         // Host writes come last: a host arm wins over a same-cycle index clear
         if (wrStb && axHit && axSel == 3'(a)) begin
            case (axOff)
               AX_CFG: begin
                  nxt_st.stepDir[a]   = wrData[CFG_STEPDIR];
                  nxt_st.roundMode[a] = wrData[CFG_ROUND];
                  nxt_st.idxInv[a]    = wrData[CFG_IDXINV];
                  nxt_st.armed[a]     = wrData[CFG_ARM];        // [R13]
                  nxt_st.cntReset[a]  = wrData[CFG_RESET];
               end
               AX_CPR:    nxt_st.cpr[a]    = wrData;
               AX_SCALE:  nxt_st.scale[a]  = wrData[15:0];
               AX_MINSPD: nxt_st.minSpd[a] = wrData;
               default: begin
               end
            endcase
         end

         if (rdStb && axHit && axSel == 3'(a)) begin
            case (axOff)
               AX_CFG:    nxt_st.rdData = {27'h0, st.cntReset[a], st.armed[a], st.idxInv[a],
                                           st.roundMode[a], st.stepDir[a]};
               AX_CPR:    nxt_st.rdData = st.cpr[a];
               AX_SCALE:  nxt_st.rdData = {16'h0000, st.scale[a]};
               AX_MINSPD: nxt_st.rdData = st.minSpd[a];
               AX_COUNT:  nxt_st.rdData = st.count[a];
               AX_RAW:    nxt_st.rdData = st.raw[a];
               AX_POS:    nxt_st.rdData = st.posOut[a];
               AX_VEL:    nxt_st.rdData = st.velOut[a];
               default:   nxt_st.rdData = '0;
            endcase
         end
      end

      // GPIO registers
      if (wrStb && page == PAGE_GPIO) begin
         case (addr[7:0])
            REG_GPIO_DIR: nxt_st.gpioDir = wrData;
            REG_GPIO_INV: nxt_st.gpioInv = wrData;
            REG_GPIO_OUT: nxt_st.gpioVal = wrData;
            default: begin
            end
         endcase
      end
      if (rdStb && page == PAGE_GPIO) begin
         case (addr[7:0])
            REG_GPIO_DIR: nxt_st.rdData = st.gpioDir;
            REG_GPIO_INV: nxt_st.rdData = st.gpioInv;
            REG_GPIO_OUT: nxt_st.rdData = st.gpioVal;
            REG_GPIO_IN:  nxt_st.rdData = gpioSync;            // [R1]
            default:      nxt_st.rdData = '0;
         endcase
      end
   end

   // ======================================================================
   // State register; timers start saturated so velocity reads zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st          <= '0;
         st.oeN      <= '1;
         st.scale    <= {AXES{SCALE_RST}};
         st.cpr      <= {AXES{CPR_RST}};
         st.interval <= {AXES{INT_SAT}};
         st.timer    <= {AXES{INT_SAT}};
      end else begin
         st <= nxt_st;
      end
   end

   assign rdData     = st.rdData;
   assign gpioPinOut = st.pinOut;
   assign gpioOeN    = st.oeN;
endmodule

`default_nettype wire

//--- mce_motion_io_assertions.sv
`default_nettype none

module mce_motion_io_assertions (
   input wire logic                       sys_clk,
   input wire logic                       rst,
   input wire logic [mce_pkg::ADDR_W-1:0] addr,
   input wire logic [mce_pkg::DATA_W-1:0] wrData,
   input wire logic                       wrStb,
   input wire logic                       rdStb,
   input wire logic [mce_pkg::DATA_W-1:0] rdData,
   input wire logic [mce_pkg::GPIO_W-1:0] gpioPinIn,
   input wire logic [mce_pkg::GPIO_W-1:0] gpioPinOut,
   input wire logic [mce_pkg::GPIO_W-1:0] gpioOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   import mce_pkg::*;
   logic dirWr;
   logic outWr;

   // Only these writes may move the pin outputs
   assign dirWr = wrStb && addr == 10'h000;
   assign outWr = wrStb && addr inside {10'h000, 10'h004, 10'h008};

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   rd_idle_zero_a: assert property (!$past(rdStb) |-> rdData == 32'h0)
      else $error("read data outside its slot");
   pin_only_out_a: assert property ((gpioPinOut & gpioOeN) == 32'h0)
      else $error("input pin carries output value");
   dir_to_oe_a: assert property (dirWr |-> ##2 gpioOeN == ~$past(wrData, 2))
      else $error("enable does not follow direction");
   oe_hold_a: assert property (!$past(dirWr, 2) |-> $stable(gpioOeN))
      else $error("enable moved without write");
   out_hold_a: assert property (!$past(outWr, 2) |-> $stable(gpioPinOut))
      else $error("pin output moved without write");
   unmapped_rd_a: assert property (rdStb && addr == 10'h1C0 |=> rdData == 32'h0)
      else $error("seventh axis answered");
   pin_read_a: assert property ($stable(gpioPinIn) [*5] ##0 (rdStb && addr == 10'h00C)
      |=> rdData == $past(gpioPinIn))
      else $error("pin level read wrong");
   dir_read_a: assert property (rdStb && addr == 10'h000 && !$past(wrStb)
      |=> rdData == ~$past(gpioOeN))
      else $error("direction readback differs from enable");

   cover property (dirWr);
   cover property (rdStb && addr == 10'h1C0);
   cover property (rdStb && addr == 10'h00C);
endmodule

bind mce_motion_io mce_motion_io_assertions chk_u (.sys_clk, .rst, .addr, .wrData, .wrStb, .rdStb,
   .rdData, .gpioPinIn, .gpioPinOut, .gpioOeN);

`default_nettype wire

//--- mce_motion_io_tb_top.sv
`default_nettype none

module mce_motion_io_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mce_pkg::*;
   logic        sys_clk = 0, rst = 1, wrStb = 0, rdStb = 0;
   logic [9:0]  addr = '0;
   logic [31:0] wrData = '0, fieldDrive = 32'hA5A5_5A00, d;
   wire  [31:0] rdData, gpioPinOut, gpioOeN, gpioPinIn;
   wire  [5:0]  encA, encB, encIdx;
   int          mismatches = 0, checks = 0;

   mce_motion_io dut_u (.sys_clk, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData, .gpioPinIn,
      .gpioPinOut, .gpioOeN, .encA, .encB, .encIdx);
   mce_field_model field_u (.sys_clk, .gpioPinOut, .gpioOeN, .fieldDrive, .gpioPinIn, .encA,
      .encB, .encIdx);

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   // ==========================================
   // Bus and compare helpers
   function automatic logic [9:0] axr(input int n, input logic [4:0] off);
      return 10'h100 + 10'(n * 32) + 10'(off);
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      wrData <= v;
      wrStb <= 1'b1;
      @(posedge sys_clk);
      wrStb <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [9:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge sys_clk);
      rdStb <= 1'b0;
      #1 v = rdData;
   endtask
   task automatic rdChk(input logic [9:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      rd(a, v);
      chk(what, v, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // ==========================================
   // Scenarios
   task automatic gpioScen;
      wr(10'h000, 32'h0000_00FF);
      wr(10'h004, 32'h0000_000F);
      wr(10'h008, 32'h0000_0F33);
      settle(6);
      chk("oeN", gpioOeN, 32'hFFFF_FF00);
      chk("pinOut", gpioPinOut, 32'h0000_003C);
      rdChk(10'h00C, 32'hA5A5_5A3C, "pinIn");
      rdChk(10'h000, 32'h0000_00FF, "dir");
      wr(10'h000, 32'h0000_0000);
      settle(3);
      chk("pinOff", gpioPinOut, 32'h0000_0000);
   endtask
   task automatic quadScen;
      field_u.quad(1, 8, 6);
      field_u.quad(1, -4, 6);
      rdChk(axr(1, AX_COUNT), 32'h4, "count");
      wr(axr(1, AX_CFG), 32'h10);
      field_u.quad(1, 2, 6);
      settle(80);
      rdChk(axr(1, AX_COUNT), 32'h0, "cntRst");
      rdChk(axr(1, AX_POS), 32'h0, "posRst");
      rdChk(axr(1, AX_RAW), 32'h6, "raw");
      wr(axr(1, AX_CFG), 32'h0);
   endtask
   task automatic stepScen;
      wr(axr(2, AX_CFG), 32'h1);
      field_u.step(2, 3, 1'b1);
      field_u.step(2, 1, 1'b0);
      rdChk(axr(2, AX_COUNT), 32'h2, "step");
      field_u.step(2, 3, 1'b0);
      rdChk(axr(2, AX_COUNT), 32'hFFFF_FFFF, "neg");
   endtask
   task automatic idxScen;
      wr(axr(3, AX_CPR), 32'h8);
      wr(axr(3, AX_CFG), 32'h8);
      field_u.quad(3, 5, 6);
      field_u.setIdx(3, 1'b1);
      rdChk(axr(3, AX_COUNT), 32'h0, "idxRst");
      rdChk(axr(3, AX_CFG), 32'h0, "disarm");
      field_u.quad(3, 7, 6);
      field_u.setIdx(3, 1'b0);
      wr(axr(3, AX_CFG), 32'hE);
      field_u.setIdx(3, 1'b1);
      rdChk(axr(3, AX_COUNT), 32'h7, "noRise");
      field_u.setIdx(3, 1'b0);
      rdChk(axr(3, AX_COUNT), 32'h8, "round");
      rdChk(axr(3, AX_CFG), 32'h6, "rndDisarm");
      rdChk(axr(3, AX_RAW), 32'hC, "rawIdx");
   endtask
   task automatic posVelScen;
      wr(axr(4, AX_SCALE), 32'h4);
      field_u.quad(4, 9, 300);
      settle(80);
      rdChk(axr(4, AX_POS), 32'h2, "pos");
      rd(axr(4, AX_VEL), d);
      chk("velUp", 32'({d[31], |d}), 32'h1);
      wr(axr(4, AX_MINSPD), 32'hFFFF_FFFF);
      settle(80);
      rdChk(axr(4, AX_VEL), 32'h0, "velMin");
   endtask
   task automatic mapScen;
      wr(10'h1C0, 32'hFFFF_FFFF);
      rdChk(10'h1C0, 32'h0, "unmapped");
      rdChk(axr(5, AX_SCALE), 32'h1, "scale5");
      wr(axr(1, AX_COUNT), 32'h55);
      rdChk(axr(1, AX_COUNT), 32'h0, "countRo");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard well past the length of the full run
   initial begin
      #200000;
      mismatches++;
      end_of_test;
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      gpioScen;
      quadScen;
      stepScen;
      idxScen;
      posVelScen;
      mapScen;
      end_of_test;
   end
endmodule

`default_nettype wire

//--- mce_pkg.sv
// Function
// (R1) Four GPIO banks of eight pins, each pin usable as input or output.
// (R2) Direction bit true drives the pin push-pull; false leaves it released as input.
// (R3) The written output value reaches a pin only while it is an output.
// (R4) Invert bit true drives the complement of the written value.
// (R5) Six independent encoder counters, each with A, B and index inputs.
// (R6) Each counter counts quadrature A/B or step/direction signals.
// (R7) Counting runs continuously, regardless of when the host reads.
// (R8) The count is a signed 32-bit value.
// (R9) While the counter reset bit is true, count and scaled position read zero.
// (R10) A raw count follows every edge and ignores reset and index.
// (R11) Scaled position equals count divided by the position scale.
// (R12) While armed, the next active index edge resets or rounds count and position.
// (R13) An index event clears the arming flag; it stays clear until the host sets it.
// (R14) Velocity comes from timing edge intervals with a hardware timer.
// (R15) Velocity magnitude below the minimum speed setting reads as zero.
// (R16) Mode bit true counts rising A edges, direction from B; false counts quadrature.
// (R17) Quadrature counts every edge of both channels, four per line.
// (R18) Round mode snaps to nearest counts-per-rev multiple; otherwise index resets.
// (R19) Index polarity bit true uses the falling index edge, otherwise rising.
// (R20) A, B and index are synchronised before edge detection.
`default_nettype none

package mce_pkg;
   // ======================================================================
   // Sizes
   localparam int ADDR_W    = 10;
   localparam int DATA_W    = 32;
   localparam int GPIO_W    = 32;      // Four banks of eight pins
   localparam int AXES      = 6;
   localparam int INT_W     = 16;      // Edge interval timer width

   // ======================================================================
   // Register map (byte addresses)
   localparam logic [1:0] PAGE_GPIO  = 2'h0;
   localparam logic [1:0] PAGE_AXIS  = 2'h1;
   localparam logic [7:0] REG_GPIO_DIR = 8'h00;
   localparam logic [7:0] REG_GPIO_INV = 8'h04;
   localparam logic [7:0] REG_GPIO_OUT = 8'h08;
   localparam logic [7:0] REG_GPIO_IN  = 8'h0C;
   // Axis n sits at 0x100 + n*0x20
   localparam logic [4:0] AX_CFG    = 5'h00;
   localparam logic [4:0] AX_CPR    = 5'h04;
   localparam logic [4:0] AX_SCALE  = 5'h08;
   localparam logic [4:0] AX_MINSPD = 5'h0C;
   localparam logic [4:0] AX_COUNT  = 5'h10;
   localparam logic [4:0] AX_RAW    = 5'h14;
   localparam logic [4:0] AX_POS    = 5'h18;
   localparam logic [4:0] AX_VEL    = 5'h1C;

   // ======================================================================
   // Axis configuration bits
   localparam int CFG_STEPDIR = 0;
   localparam int CFG_ROUND   = 1;
   localparam int CFG_IDXINV  = 2;
   localparam int CFG_ARM     = 3;
   localparam int CFG_RESET   = 4;

   // ======================================================================
   // Reset values
   localparam logic [15:0] SCALE_RST = 16'h0001;
   localparam logic [31:0] CPR_RST   = 32'h0000_0000;
   localparam logic [INT_W-1:0] INT_SAT = 16'hFFFF;

   // ======================================================================
   // Timing
   localparam int CLK_PERIOD_NS   = 4;
   localparam int TIMER_PERIOD_NS = 1000;
   localparam int TICK_CYCLES     = (TIMER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  TICK_LAST = 8'(TICK_CYCLES - 1);
   localparam logic [31:0] TIMER_HZ  = 32'(1000000000 / TIMER_PERIOD_NS);
endpackage

`default_nettype wire

//--- mce_sync.sv
`default_nettype none

module mce_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   import mce_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } mce_sync_state_t;

   mce_sync_state_t st;
   mce_sync_state_t nxt_st;

   // ======================================================================
   // Three stages; a bit changes only once stages two and three agree,
   // which rejects a single-cycle glitch at the cost of one cycle latency
   always_comb begin
      nxt_st    = st;
      nxt_st.s1 = din;
      nxt_st.s2 = st.s1;
      nxt_st.s3 = st.s2;
      nxt_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3)); // [R20]
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nxt_st;
      end
   end

   assign dout = st.q;
endmodule

`default_nettype wire
